// [logic/rss_pkg.sv]
`default_nettype none
package rss_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_OUT_RESET_NS_DFLT = 20000;
  localparam int DELAY_SHORT_CYC = 256;
  localparam int DELAY_LONG_CYC = 4096;
  localparam logic [11:0] DELAY_SHORT_LAST = 12'(DELAY_SHORT_CYC - 1);
  localparam logic [11:0] DELAY_LONG_LAST = 12'(DELAY_LONG_CYC - 1);
  localparam int FETCH_CYC = 2;
  localparam logic FETCH_LAST = 1'(FETCH_CYC - 1);
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
  localparam int BLANK_CYC = 3;
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STAT_OFFSET = 4'h4;
  localparam int CTRL_SRC_BIT = 7;
  localparam int CTRL_IE_BIT = 6;
  localparam int CTRL_FLAG_BIT = 5;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_LVL_LSB = 1;
  localparam int STAT_LVDEN_BIT = 3;
  localparam int STAT_LONG_BIT = 4;
  localparam int STAT_SEQ_LSB = 5;
  localparam logic SRC_SEL_RST = 1'b0;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic [1:0] LVD_LEVEL_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_ACTIVE = 2'b01,
    SEQ_DELAY = 2'b10,
    SEQ_FETCH = 2'b11
  } rss_seq_t;
endpackage
`default_nettype wire

// [logic/rss_reset_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE1] Three reset causes: external pin pulse, low-voltage detector, watchdog underflow.
// [RULE2] Every cause drives the reset pin; pin held low through the whole delay.
// [RULE3] Reset vector is fetched from the address pair FFFEh-FFFFh.
// [RULE4] Phases in order: active, 256 or 4096 cycle delay by option, vector fetch.
// [RULE5] Vector fetch phase lasts exactly two clock cycles.
// [RULE6] External reset detection needs no CPU activity; works even when halted.
// [RULE7] Reset pin is input plus open-drain output; device only drives it low.
// [RULE8] After an external pulse the device holds the pin low for the minimum width.
// [RULE9] Watchdog underflow drives the pin low for the minimum width, then sequences.
// [RULE10] While the low-voltage detector is active, the pin stays driven low.
// [RULE11] Low-voltage detector enabled by option, threshold low, medium or high.
// [RULE12] Auxiliary detector, flag and interrupt work only with the detector enabled.
// [RULE13] Auxiliary compare flag is read-only and follows the comparator live.
// [RULE14] Source select cleared: compare the main supply.
// [RULE15] Source select set: compare the external sense pin.
// [RULE16] With enable set, every flag change in either direction raises an interrupt; the code drops changes of either direction during the reset sequence.
// [RULE17] A rising crossing during the reset sequence raises no interrupt.
// [RULE18] Enabling while below the upper threshold gives an interrupt at enable time.
// [RULE19] Enabling after the upper threshold was passed gives no extra interrupt.
// [RULE20] Flag reads 0 above the upper threshold, 1 below the lower threshold.
// [RULE21] Pending interrupt clears when the CPU enters the service routine.
// [RULE22] Delay counts only after all causes release; a new cause restarts it.
// [RULE23] Comparator inputs are synchronised before edge detection.
module rss_reset_sequencer #(
  parameter int MIN_OUT_RESET_NS = rss_pkg::MIN_OUT_RESET_NS_DFLT
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [rss_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rss_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  input wire logic optLvdEnable,
  input wire logic [1:0] optLvdLevel,
  input wire logic optLongDelay,
  input wire logic lvdDetect,
  input wire logic watchdogUnderflow,
  input wire logic auxVddAboveUpper,
  input wire logic auxVddBelowLower,
  input wire logic evdAboveUpper,
  input wire logic evdBelowLower,
  input wire logic irqAck,
  output logic [1:0] lvdLevelSel,
  output logic cpuResetN,
  output logic vectorFetch,
  output logic [15:0] vectorAddr,
  output logic auxIrq
);
  localparam int WIDTH_CYC_RAW =
    (MIN_OUT_RESET_NS + rss_pkg::CLK_PERIOD_NS - 1) / rss_pkg::CLK_PERIOD_NS;
  localparam int WIDTH_CYC = (WIDTH_CYC_RAW < 1) ? 1 : WIDTH_CYC_RAW;
  // The pin is driven while the count is below this, so it stays low for WIDTH_CYC cycles
  localparam logic [15:0] WIDTH_LAST = 16'(WIDTH_CYC);

  rss_pkg::rss_seq_t seq_q;
  rss_pkg::rss_seq_t seq_d;
  logic [15:0] widthCnt_q;
  logic [11:0] delayCnt_q;
  logic fetchCnt_q;
  logic optLvdEn_q;
  logic optLong_q;
  logic [1:0] optLevel_q;
  logic pinMeta_q;
  logic pinSync_q;
  logic lvdMeta_q;
  logic lvdSync_q;
  logic [3:0] cmpMeta_q;
  logic [3:0] cmpSync_q;
  logic [rss_pkg::BLANK_CYC-1:0] oeDly_q;
  logic srcSel_q;
  logic irqEn_q;
  logic irqEnPrev_q;
  logic flag_q;
  logic flagPrev_q;
  logic pend_q;
  logic awHeld_q;
  logic wHeld_q;
  logic [rss_pkg::ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic lvdCause;
  logic extLow;
  logic intCause;
  logic [11:0] delayLast;
  logic widthDone;
  logic cmpHigh;
  logic cmpLow;
  logic irqSet;
  logic wrFire;
  logic [15:0] oeLen_q;

  // Option bits are straps: caught while reset is held, stable afterwards
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      optLvdEn_q <= optLvdEnable;
      optLong_q <= optLongDelay;
      optLevel_q <= optLvdLevel;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
      lvdMeta_q <= 1'b0;
      lvdSync_q <= 1'b0;
      cmpMeta_q <= 4'h0;
      cmpSync_q <= 4'h0;
    end
    else if (clk_en)
    begin
      pinMeta_q <= resetPinIn;
      pinSync_q <= pinMeta_q;
      lvdMeta_q <= lvdDetect;
      lvdSync_q <= lvdMeta_q;
      cmpMeta_q <= {evdBelowLower, evdAboveUpper, auxVddBelowLower, auxVddAboveUpper}; // [RULE23]
      cmpSync_q <= cmpMeta_q; // [RULE23]
    end
  end

  // Our own drive reads back low through the synchroniser; blank it out
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      oeDly_q <= '1;
    else if (clk_en)
      oeDly_q <= {oeDly_q[rss_pkg::BLANK_CYC-2:0], resetPinOe};
  end

  assign lvdCause = lvdSync_q && optLvdEn_q; // [RULE11]
  assign extLow = !pinSync_q && !resetPinOe && (oeDly_q == '0); // [RULE6]
  assign intCause = lvdCause || watchdogUnderflow; // [RULE1]
  assign delayLast = optLong_q ? rss_pkg::DELAY_LONG_LAST : rss_pkg::DELAY_SHORT_LAST; // [RULE4]
  assign widthDone = (widthCnt_q == WIDTH_LAST);

  always_comb
  begin
    seq_d = seq_q;
    unique case (seq_q)
      rss_pkg::SEQ_RUN:
        if (intCause || extLow) // [RULE1]
          seq_d = rss_pkg::SEQ_ACTIVE;
      rss_pkg::SEQ_ACTIVE:
        if (widthDone && !intCause && pinSync_q && (oeDly_q == '0))
          seq_d = rss_pkg::SEQ_DELAY; // [RULE22]
      rss_pkg::SEQ_DELAY:
        if (intCause)
          seq_d = rss_pkg::SEQ_ACTIVE; // [RULE22]
        else if (delayCnt_q == delayLast)
          seq_d = rss_pkg::SEQ_FETCH; // [RULE4]
      rss_pkg::SEQ_FETCH:
        if (intCause)
          seq_d = rss_pkg::SEQ_ACTIVE;
        else if (fetchCnt_q == rss_pkg::FETCH_LAST)
          seq_d = rss_pkg::SEQ_RUN; // [RULE5]
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      seq_q <= rss_pkg::SEQ_ACTIVE;
    else if (clk_en)
      seq_q <= seq_d;
  end

  // Width counter restarts on entry and on every low-voltage or watchdog cause, so a watchdog pulse always gets full width
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      widthCnt_q <= 16'h0000;
    else if (clk_en)
    begin
      if (seq_d == rss_pkg::SEQ_ACTIVE && (seq_q != rss_pkg::SEQ_ACTIVE || intCause))
        widthCnt_q <= 16'h0000; // [RULE8] [RULE9]
      else if (seq_q == rss_pkg::SEQ_ACTIVE && !widthDone)
        widthCnt_q <= widthCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      delayCnt_q <= 12'h000;
    else if (clk_en)
    begin
      if (seq_q == rss_pkg::SEQ_DELAY && seq_d == rss_pkg::SEQ_DELAY)
        delayCnt_q <= delayCnt_q + 12'h001; // [RULE4]
      else
        delayCnt_q <= 12'h000; // [RULE22]
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      fetchCnt_q <= 1'b0;
    else if (clk_en)
      fetchCnt_q <= (seq_q == rss_pkg::SEQ_FETCH) ? !fetchCnt_q : 1'b0; // [RULE5]
  end

  assign resetPinOut = 1'b0; // [RULE7]
  assign resetPinOe = (seq_q == rss_pkg::SEQ_DELAY) || // [RULE2]
    (seq_q == rss_pkg::SEQ_ACTIVE && (!widthDone || lvdCause)); // [RULE8] [RULE9] [RULE10]
  assign cpuResetN = (seq_q == rss_pkg::SEQ_RUN);
  assign vectorFetch = (seq_q == rss_pkg::SEQ_FETCH);
  assign vectorAddr = {rss_pkg::RESET_VECTOR_ADDR[15:1], fetchCnt_q}; // [RULE3]
  assign lvdLevelSel = optLvdEn_q ? optLevel_q : rss_pkg::LVD_LEVEL_RST; // [RULE11]

  assign cmpHigh = srcSel_q ? cmpSync_q[2] : cmpSync_q[0]; // [RULE14] [RULE15]
  assign cmpLow = srcSel_q ? cmpSync_q[3] : cmpSync_q[1]; // [RULE14] [RULE15]

  // Hysteresis band holds the last level; no software latch beyond that
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      flag_q <= 1'b0;
      flagPrev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!optLvdEn_q)
        flag_q <= 1'b0; // [RULE12]
      else if (cmpHigh)
        flag_q <= 1'b0; // [RULE20]
      else if (cmpLow)
        flag_q <= 1'b1; // [RULE20]
      flagPrev_q <= flag_q;
    end
  end

  // Edges seen while the sequencer is busy are dropped, not deferred
  assign irqSet = optLvdEn_q && irqEn_q && cpuResetN && // [RULE12] [RULE17]
    ((flag_q != flagPrev_q) || (!irqEnPrev_q && flag_q)); // [RULE16] [RULE18] [RULE19]

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pend_q <= 1'b0;
      irqEnPrev_q <= rss_pkg::IRQ_EN_RST;
    end
    else if (clk_en)
    begin
      irqEnPrev_q <= irqEn_q;
      if (irqSet)
        pend_q <= 1'b1; // [RULE16]
      else if (irqAck)
        pend_q <= 1'b0; // [RULE21]
    end
  end

  assign auxIrq = pend_q;

  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready = !wHeld_q && !bvalid_q;
  assign wrFire = awHeld_q && wHeld_q && !bvalid_q;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= rss_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awAddr_q[3:2] == rss_pkg::CTRL_OFFSET[3:2] ||
          awAddr_q[3:2] == rss_pkg::STAT_OFFSET[3:2]) ? rss_pkg::RESP_OKAY : rss_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      srcSel_q <= rss_pkg::SRC_SEL_RST;
      irqEn_q <= rss_pkg::IRQ_EN_RST;
    end
    else if (clk_en && wrFire && wStrb_q[0] &&
      awAddr_q[3:2] == rss_pkg::CTRL_OFFSET[3:2])
    begin
      srcSel_q <= wData_q[rss_pkg::CTRL_SRC_BIT]; // [RULE14] [RULE15]
      irqEn_q <= wData_q[rss_pkg::CTRL_IE_BIT];
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= rss_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && !rvalid_q)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= rss_pkg::RESP_OKAY;
        rdata_q <= 32'h00000000;
        if (s_axi_araddr[3:2] == rss_pkg::CTRL_OFFSET[3:2])
        begin
          rdata_q[rss_pkg::CTRL_SRC_BIT] <= srcSel_q;
          rdata_q[rss_pkg::CTRL_IE_BIT] <= irqEn_q;
          rdata_q[rss_pkg::CTRL_FLAG_BIT] <= flag_q; // [RULE13]
        end
        else if (s_axi_araddr[3:2] == rss_pkg::STAT_OFFSET[3:2])
        begin
          rdata_q[rss_pkg::STAT_PEND_BIT] <= pend_q;
          rdata_q[rss_pkg::STAT_LVL_LSB +: 2] <= optLevel_q;
          rdata_q[rss_pkg::STAT_LVDEN_BIT] <= optLvdEn_q;
          rdata_q[rss_pkg::STAT_LONG_BIT] <= optLong_q;
          rdata_q[rss_pkg::STAT_SEQ_LSB +: 2] <= seq_q;
        end
        else
          rresp_q <= rss_pkg::RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  AST_DELAY_PIN_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE2]
    (seq_q == rss_pkg::SEQ_DELAY) |-> (resetPinOe && resetPinOut == 1'b0))
    else $error("reset pin released during delay");

  AST_ONLY_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE7]
    resetPinOe |-> !resetPinOut)
    else $error("reset pin driven high");

  AST_FETCH_ADDR: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE3]
    (vectorFetch && clk_en && !intCause && !fetchCnt_q) |=>
      (vectorFetch && vectorAddr == 16'hFFFF))
    else $error("vector fetch address sequence wrong");

  AST_FETCH_LEN: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE5]
    (vectorFetch && fetchCnt_q && clk_en && !intCause) |=> (cpuResetN && !vectorFetch))
    else $error("fetch phase not two cycles");

  AST_DELAY_DONE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE4]
    (vectorFetch && $past(seq_q) == rss_pkg::SEQ_DELAY) |-> $past(delayCnt_q) == delayLast)
    else $error("delay phase length wrong");

  AST_RESTART: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE22]
    (seq_q == rss_pkg::SEQ_DELAY && intCause && clk_en) |=>
      (seq_q == rss_pkg::SEQ_ACTIVE && widthCnt_q == 16'h0000))
    else $error("delay not restarted by new cause");

  AST_WDG_DRIVE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE9]
    (watchdogUnderflow && clk_en) |=> (resetPinOe && !cpuResetN))
    else $error("watchdog did not drive reset pin");

  AST_LVD_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE10]
    (lvdCause && clk_en) ##1 lvdCause |-> resetPinOe)
    else $error("pin released while low-voltage reset active");

  // Separate count of the pin's low time, so the check does not lean on the width counter
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      oeLen_q <= 16'h0000;
    else if (clk_en)
    begin
      if (!resetPinOe)
        oeLen_q <= 16'h0000;
      else if (oeLen_q != 16'hFFFF)
        oeLen_q <= oeLen_q + 16'h0001;
    end
  end

  AST_MIN_WIDTH: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE8]
    (seq_q == rss_pkg::SEQ_ACTIVE && !resetPinOe && $past(resetPinOe)) |->
      (oeLen_q >= 16'(WIDTH_CYC)))
    else $error("reset output shorter than minimum width");

  AST_FLAG_LEVEL: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE20]
    (clk_en && optLvdEn_q && cmpHigh) |=> !flag_q)
    else $error("flag not clear above upper threshold");

  AST_TOGGLE_IRQ: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE16]
    (clk_en && irqEn_q && optLvdEn_q && cpuResetN && $changed(flag_q)) |=> auxIrq)
    else $error("flag toggle gave no interrupt");

  AST_NO_IRQ_IN_RESET: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE17]
    (!cpuResetN && !auxIrq) |=> !auxIrq)
    else $error("interrupt raised during reset sequence");

  AST_ACK_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE21]
    (clk_en && irqAck && !irqSet) |=> !auxIrq)
    else $error("pending interrupt not cleared by entry");

endmodule
`default_nettype wire

// [dv/rss_reset_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rss_reset_line_model (
  input wire logic ref_clk,
  input wire logic devOe,
  input wire logic pulseStart,
  input wire logic [15:0] pulseLen,
  output logic pinLevel
);
  logic [15:0] lowLeft_q = 16'h0;
  always_ff @(posedge ref_clk)
  begin
    if (pulseStart)
      lowLeft_q <= pulseLen;
    else if (lowLeft_q != 16'h0)
      lowLeft_q <= lowLeft_q - 16'h1;
  end
  // Wired-low line: the weak pull-up wins only when nobody sinks it
  assign pinLevel = !(devOe || (lowLeft_q != 16'h0));
endmodule
`default_nettype wire

// [dv/reset_sequencer_supply_monitor_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    nChecks++; \
    if ((got) !== (exp)) \
    begin \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
      failCount++; \
    end \
  end
module reset_sequencer_supply_monitor_test;
  localparam int WIDTH = 5;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, resetPinIn, resetPinOut, resetPinOe, cpuResetN, vectorFetch, auxIrq;
  logic [1:0] s_axi_bresp, s_axi_rresp, lvdLevelSel, rsp;
  logic [15:0] vectorAddr, pulseLen = 16'h0;
  logic optLvdEnable = 1'b1, optLongDelay = 1'b0, lvdDetect = 1'b0, watchdogUnderflow = 1'b0;
  logic auxVddAboveUpper = 1'b1, auxVddBelowLower = 1'b0;
  logic evdAboveUpper = 1'b1, evdBelowLower = 1'b0;
  logic irqAck = 1'b0, pulseStart = 1'b0, clkEn = 1'b1;
  logic [1:0] optLvdLevel = 2'h2;
  int failCount = 0, nChecks = 0, cycles = 0;

  rss_reset_sequencer #(.MIN_OUT_RESET_NS(50)) rss_reset_sequencer_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clkEn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .resetPinIn(resetPinIn),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .optLvdEnable(optLvdEnable),
    .optLvdLevel(optLvdLevel), .optLongDelay(optLongDelay), .lvdDetect(lvdDetect),
    .watchdogUnderflow(watchdogUnderflow), .auxVddAboveUpper(auxVddAboveUpper),
    .auxVddBelowLower(auxVddBelowLower), .evdAboveUpper(evdAboveUpper),
    .evdBelowLower(evdBelowLower), .irqAck(irqAck), .lvdLevelSel(lvdLevelSel),
    .cpuResetN(cpuResetN), .vectorFetch(vectorFetch), .vectorAddr(vectorAddr), .auxIrq(auxIrq)
  );
  rss_reset_line_model rss_reset_line_model_inst (
    .ref_clk(ref_clk), .devOe(resetPinOe), .pulseStart(pulseStart), .pulseLen(pulseLen),
    .pinLevel(resetPinIn)
  );

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  task finishTest;
    $display("Checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Ceiling covers one long-delay sequence plus several short ones
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failCount++;
      finishTest();
    end
  end

  task cycWait(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Ready and valid are sampled mid-cycle, where they hold the values of the next edge
  task axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] expResp);
    logic awT, wT, bT;
    bT = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Only the bench timeout ends a wait for the response
    while (!bT)
    begin
      @(negedge ref_clk);
      awT = s_axi_awvalid && s_axi_awready;
      wT = s_axi_wvalid && s_axi_wready;
      bT = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge ref_clk);
      if (awT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
      if (bT) s_axi_bready <= 1'b0;
    end
    `CHK("bresp", expResp, rsp)
  endtask

  task readChk(input logic [3:0] a, input logic [1:0] er, input logic [31:0] m,
               input logic [31:0] e, input string nm);
    logic arT, rT;
    rT = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rT)
    begin
      @(negedge ref_clk);
      arT = s_axi_arvalid && s_axi_arready;
      rT = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge ref_clk);
      if (arT) s_axi_arvalid <= 1'b0;
      if (rT) s_axi_rready <= 1'b0;
    end
    `CHK("rresp", er, rsp)
    `CHK(nm, e, rd & m)
  endtask

  task waitReset;
    int i;
    i = 0;
    // Callers return on a rising edge; look only where outputs have settled
    @(negedge ref_clk);
    while (!resetPinOe && i < 20)
    begin
      i++;
      @(negedge ref_clk);
    end
    `CHK("pinDriven", 1'b1, resetPinOe)
    `CHK("cpuHeld", 1'b0, cpuResetN)
  endtask

  task runSequence(input int expDelay);
    int act, gap, dly, low;
    act = 0;
    gap = 0;
    dly = 0;
    low = 0;
    // Entered on a falling edge at which the pin is already driven; that cycle counts
    while (resetPinOe && act < 5000)
    begin
      act++;
      @(negedge ref_clk);
    end
    while (!resetPinOe && gap < 20)
    begin
      gap++;
      @(negedge ref_clk);
    end
    while (!vectorFetch && dly < 5000)
    begin
      dly++;
      low += !resetPinOe;
      @(negedge ref_clk);
    end
    `CHK("activeWidth", 1'b1, act >= WIDTH)
    `CHK("delayLen", 1'b1, dly >= expDelay - 1 && dly <= expDelay + 2)
    `CHK("delayPinLow", 0, low)
    `CHK("fetchAddrLo", 16'hFFFE, vectorAddr)
    @(negedge ref_clk);
    `CHK("fetchSecond", 1'b1, vectorFetch)
    `CHK("fetchAddrHi", 16'hFFFF, vectorAddr)
    @(negedge ref_clk);
    `CHK("fetchOver", 1'b0, vectorFetch)
    `CHK("cpuRun", 1'b1, cpuResetN)
  endtask

  task ackIrq;
    @(posedge ref_clk);
    irqAck <= 1'b1;
    @(posedge ref_clk);
    irqAck <= 1'b0;
    cycWait(1);
  endtask

  // Levels in order: supply above upper, supply below lower, pin above upper, pin below lower
  task setAux(input logic [3:0] lv);
    @(posedge ref_clk);
    {auxVddAboveUpper, auxVddBelowLower, evdAboveUpper, evdBelowLower} <= lv;
    cycWait(8);
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    `CHK("cpuInReset", 1'b0, cpuResetN)
    `CHK("pinData", 1'b0, resetPinOut)
    runSequence(rss_pkg::DELAY_SHORT_CYC);
    readChk(rss_pkg::CTRL_OFFSET, rss_pkg::RESP_OKAY, 32'hE0, 32'h0, "ctrlReset");
    readChk(rss_pkg::STAT_OFFSET, rss_pkg::RESP_OKAY, 32'h7F, 32'h0C, "status");
    `CHK("levelSel", 2'h2, lvdLevelSel)
    readChk(4'h8, rss_pkg::RESP_SLVERR, 32'hFFFFFFFF, 32'h0, "unmapped");
    axiWrite(4'hC, 32'hC0, rss_pkg::RESP_SLVERR);
    readChk(rss_pkg::CTRL_OFFSET, rss_pkg::RESP_OKAY, 32'hC0, 32'h0, "ctrlUntouched");
    axiWrite(rss_pkg::CTRL_OFFSET, 32'h40, rss_pkg::RESP_OKAY);
    cycWait(8);
    `CHK("enableAbove", 1'b0, auxIrq)
    // A frozen clock enable must hold the comparator edge until it is released
    @(posedge ref_clk);
    clkEn <= 1'b0;
    setAux(4'h6);
    `CHK("frozenIrq", 1'b0, auxIrq)
    @(posedge ref_clk);
    clkEn <= 1'b1;
    cycWait(8);
    `CHK("fallIrq", 1'b1, auxIrq)
    readChk(rss_pkg::CTRL_OFFSET, rss_pkg::RESP_OKAY, 32'h20, 32'h20, "flagLow");
    ackIrq();
    `CHK("ackClears", 1'b0, auxIrq)
    setAux(4'hA);
    `CHK("riseIrq", 1'b1, auxIrq)
    readChk(rss_pkg::CTRL_OFFSET, rss_pkg::RESP_OKAY, 32'h20, 32'h0, "flagHigh");
    ackIrq();
    axiWrite(rss_pkg::CTRL_OFFSET, 32'hC0, rss_pkg::RESP_OKAY);
    setAux(4'h6);
    readChk(rss_pkg::CTRL_OFFSET, rss_pkg::RESP_OKAY, 32'hE0, 32'hC0, "pinSelIgnVdd");
    `CHK("noIrqVdd", 1'b0, auxIrq)
    setAux(4'h5);
    readChk(rss_pkg::CTRL_OFFSET, rss_pkg::RESP_OKAY, 32'h20, 32'h20, "pinFlag");
    `CHK("pinIrq", 1'b1, auxIrq)
    ackIrq();
    axiWrite(rss_pkg::CTRL_OFFSET, 32'h80, rss_pkg::RESP_OKAY);
    cycWait(4);
    `CHK("disabled", 1'b0, auxIrq)
    axiWrite(rss_pkg::CTRL_OFFSET, 32'hC0, rss_pkg::RESP_OKAY);
    cycWait(4);
    `CHK("enableBelow", 1'b1, auxIrq)
    ackIrq();
    setAux(4'hA);
    ackIrq();
    // Enable stays set so that flag edges during the low-voltage reset sequence are exercised
    axiWrite(rss_pkg::CTRL_OFFSET, 32'h40, rss_pkg::RESP_OKAY);
    @(posedge ref_clk);
    watchdogUnderflow <= 1'b1;
    @(posedge ref_clk);
    watchdogUnderflow <= 1'b0;
    waitReset();
    runSequence(rss_pkg::DELAY_SHORT_CYC);
    @(posedge ref_clk);
    pulseLen <= 16'h2;
    pulseStart <= 1'b1;
    @(posedge ref_clk);
    pulseStart <= 1'b0;
    waitReset();
    runSequence(rss_pkg::DELAY_SHORT_CYC);
    @(posedge ref_clk);
    lvdDetect <= 1'b1;
    waitReset();
    cycWait(50);
    setAux(4'h6);
    setAux(4'hA);
    `CHK("noIrqInReset", 1'b0, auxIrq)
    `CHK("lvdHoldsPin", 1'b1, resetPinOe)
    @(posedge ref_clk);
    lvdDetect <= 1'b0;
    cycWait(0);
    runSequence(rss_pkg::DELAY_SHORT_CYC);
    @(posedge ref_clk);
    optLvdEnable <= 1'b0;
    optLongDelay <= 1'b1;
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    cycWait(0);
    runSequence(rss_pkg::DELAY_LONG_CYC);
    readChk(rss_pkg::STAT_OFFSET, rss_pkg::RESP_OKAY, 32'h7F, 32'h14, "statusLong");
    `CHK("levelOff", 2'h0, lvdLevelSel)
    axiWrite(rss_pkg::CTRL_OFFSET, 32'h40, rss_pkg::RESP_OKAY);
    setAux(4'h6);
    readChk(rss_pkg::CTRL_OFFSET, rss_pkg::RESP_OKAY, 32'h20, 32'h0, "auxOff");
    `CHK("auxOffIrq", 1'b0, auxIrq)
    finishTest();
  end
endmodule
`default_nettype wire
